// ===== design/cmp_one_pkg.sv
// Purpose: constants and carrier types for the comparator one control registers
// Assumes: byte-wide special function register port, system clock at 100 MHz
// Notes: offsets are the special function addresses, valid on every register page
package cmp_one_pkg;
   localparam logic [7:0] control_addr = 8'h9a;
   localparam logic [7:0] mode_addr = 8'h9c;
   localparam logic [7:0] input_select_addr = 8'h9e;

   localparam logic [7:0] control_reset = 8'h00;
   localparam logic [7:0] mode_reset = 8'h02;
   localparam logic [7:0] input_select_reset = 8'hff;

   localparam int enable_bit = 7;
   localparam int output_bit = 6;
   localparam int rise_bit = 5;
   localparam int fall_bit = 4;
   localparam int pos_hyst_lsb = 2;
   localparam int neg_hyst_lsb = 0;
   localparam int inv_sel_lsb = 4;
   localparam int noninv_sel_lsb = 0;
   localparam int rise_ie_bit = 5;
   localparam int fall_ie_bit = 4;
   localparam int resp_mode_lsb = 0;

   localparam logic [7:0] input_select_fixed = 8'hcc;
   localparam logic [7:0] mode_writable = 8'h33;

   typedef struct packed {
      logic enable;
      logic [1:0] pos_hyst;
      logic [1:0] neg_hyst;
      logic [1:0] inv_sel;
      logic [1:0] noninv_sel;
      logic [1:0] resp_mode;
   } analog_ctrl_s;
endpackage

// ===== design/cmp_one_regs.sv
// Purpose: register bank and edge flags for comparator one
// Assumes: register port inputs synchronous to clock; cmp_raw is asynchronous
// Notes: writes take effect at the clock edge where wr_en is high
`timescale 1ns/1ns
module cmp_one_regs (
   input wire logic clock,
   input wire logic rstn,
   input wire logic [7:0] addr,
   input wire logic wr_en,
   input wire logic [7:0] wr_data,
   input wire logic rd_en,
   output logic [7:0] rd_data,
   output logic rd_hit,
   input wire logic cmp_raw,
   output cmp_one_pkg::analog_ctrl_s analog_ctrl,
   output logic cmp_pin_out,
   output logic rise_irq,
   output logic fall_irq
);
   logic [7:0] control_q;
   logic [7:0] mode_q;
   logic [7:0] input_select_q;
   logic sync1_q;
   logic sync2_q;
   logic rise_q;
   logic fall_q;
   logic rise_evt;
   logic fall_evt;
   logic wr_ctrl;
   logic [7:0] rd_d;
   logic hit_d;

   assign wr_ctrl = wr_en && (addr == cmp_one_pkg::control_addr);

   // first stage feeds only the second
   always_ff @(posedge clock) begin
      if (!rstn) begin
         sync1_q <= 1'b0;
         sync2_q <= 1'b0;
      end else begin
         sync1_q <= cmp_raw;
         sync2_q <= sync1_q;
      end
   end

   // disabled comparator reads and routes as low, so disabling gives a falling edge
   logic live_out;
   assign live_out = sync2_q && control_q[cmp_one_pkg::enable_bit];
   logic live_prev_q;
   always_ff @(posedge clock) begin
      if (!rstn) begin
         live_prev_q <= 1'b0;
      end else begin
         live_prev_q <= live_out;
      end
   end
   assign rise_evt = live_out && !live_prev_q;
   assign fall_evt = !live_out && live_prev_q;

   // set wins over a clearing write in the same cycle
   always_ff @(posedge clock) begin
      if (!rstn) begin
         rise_q <= 1'b0;
         fall_q <= 1'b0;
      end else begin
         if (rise_evt) begin
            rise_q <= 1'b1;
         end else if (wr_ctrl) begin
            rise_q <= wr_data[cmp_one_pkg::rise_bit];
         end
         if (fall_evt) begin
            fall_q <= 1'b1;
         end else if (wr_ctrl) begin
            fall_q <= wr_data[cmp_one_pkg::fall_bit];
         end
      end
   end

   always_ff @(posedge clock) begin
      if (!rstn) begin
         control_q <= cmp_one_pkg::control_reset;
      end else if (wr_ctrl) begin
         control_q <= wr_data;
      end
   end

   always_ff @(posedge clock) begin
      if (!rstn) begin
         mode_q <= cmp_one_pkg::mode_reset;
      end else if (wr_en && addr == cmp_one_pkg::mode_addr) begin
         mode_q <= wr_data & cmp_one_pkg::mode_writable;
      end
   end

   always_ff @(posedge clock) begin
      if (!rstn) begin
         input_select_q <= cmp_one_pkg::input_select_reset;
      end else if (wr_en && addr == cmp_one_pkg::input_select_addr) begin
         input_select_q <= wr_data | cmp_one_pkg::input_select_fixed;
      end
   end

   always_comb begin
      rd_d = 8'h00;
      hit_d = 1'b1;
      if (addr == cmp_one_pkg::control_addr) begin
         rd_d = control_q;
         rd_d[cmp_one_pkg::output_bit] = live_out;
         rd_d[cmp_one_pkg::rise_bit] = rise_q;
         rd_d[cmp_one_pkg::fall_bit] = fall_q;
      end else if (addr == cmp_one_pkg::mode_addr) begin
         rd_d = mode_q & cmp_one_pkg::mode_writable;
      end else if (addr == cmp_one_pkg::input_select_addr) begin
         rd_d = input_select_q | cmp_one_pkg::input_select_fixed;
      end else begin
         hit_d = 1'b0;
      end
   end

   // read data registered one cycle after rd_en; unmapped address reads zero
   always_ff @(posedge clock) begin
      if (!rstn) begin
         rd_data <= 8'h00;
         rd_hit <= 1'b0;
      end else if (rd_en) begin
         rd_data <= rd_d;
         rd_hit <= hit_d;
      end else begin
         rd_hit <= 1'b0;
      end
   end

   always_comb begin
      analog_ctrl.enable = control_q[cmp_one_pkg::enable_bit];
      analog_ctrl.pos_hyst = control_q[cmp_one_pkg::pos_hyst_lsb +: 2];
      analog_ctrl.neg_hyst = control_q[cmp_one_pkg::neg_hyst_lsb +: 2];
      analog_ctrl.inv_sel = input_select_q[cmp_one_pkg::inv_sel_lsb +: 2];
      analog_ctrl.noninv_sel = input_select_q[cmp_one_pkg::noninv_sel_lsb +: 2];
      analog_ctrl.resp_mode = mode_q[cmp_one_pkg::resp_mode_lsb +: 2];
   end

   always_ff @(posedge clock) begin
      if (!rstn) begin
         cmp_pin_out <= 1'b0;
      end else begin
         cmp_pin_out <= live_out;
      end
   end

   assign rise_irq = rise_q && mode_q[cmp_one_pkg::rise_ie_bit];
   assign fall_irq = fall_q && mode_q[cmp_one_pkg::fall_ie_bit];

   property p_rise_sets;
      @(posedge clock) disable iff (!rstn) rise_evt |=> rise_q;
   endproperty
   a_rise_sets: assert property (p_rise_sets) else $error("rise flag not set");

   property p_fall_sets;
      @(posedge clock) disable iff (!rstn) fall_evt |=> fall_q;
   endproperty
   a_fall_sets: assert property (p_fall_sets) else $error("fall flag not set");

   property p_flag_sticky;
      @(posedge clock) disable iff (!rstn) (rise_q && !wr_ctrl) |=> rise_q;
   endproperty
   a_flag_sticky: assert property (p_flag_sticky) else $error("rise flag cleared by hw");

   property p_fall_sticky;
      @(posedge clock) disable iff (!rstn) (fall_q && !wr_ctrl) |=> fall_q;
   endproperty
   a_fall_sticky: assert property (p_fall_sticky) else $error("fall flag cleared by hw");

   // two flops exactly: the raw level reaches the edge detector two edges later
   property p_sync_delay;
      @(posedge clock) disable iff (!rstn)
         $rose(sync2_q) |-> $past(cmp_raw, 2);
   endproperty
   a_sync_delay: assert property (p_sync_delay) else $error("sync path broken");

   property p_pin_low_off;
      @(posedge clock) disable iff (!rstn) !control_q[cmp_one_pkg::enable_bit] |=> !cmp_pin_out;
   endproperty
   a_pin_low_off: assert property (p_pin_low_off) else $error("pin high while disabled");

   property p_rise_irq;
      @(posedge clock) disable iff (!rstn) rise_irq == (rise_q && mode_q[5]);
   endproperty
   a_rise_irq: assert property (p_rise_irq) else $error("rise irq gating wrong");

   property p_fall_irq;
      @(posedge clock) disable iff (!rstn) !mode_q[4] |-> !fall_irq;
   endproperty
   a_fall_irq: assert property (p_fall_irq) else $error("fall irq not masked");

   property p_mux_fixed;
      @(posedge clock) disable iff (!rstn) input_select_q[7:6] == 2'h3 && input_select_q[3:2] == 2'h3;
   endproperty
   a_mux_fixed: assert property (p_mux_fixed) else $error("mux unused bits not 11");

   property p_mode_zero;
      @(posedge clock) disable iff (!rstn) mode_q[7:6] == 2'h0 && mode_q[3:2] == 2'h0;
   endproperty
   a_mode_zero: assert property (p_mode_zero) else $error("mode unused bits set");

   property p_mode_reset;
      @(posedge clock) $rose(rstn) |-> mode_q == 8'h02 && control_q == 8'h00 && input_select_q == 8'hff;
   endproperty
   a_mode_reset: assert property (p_mode_reset) else $error("reset values wrong");

   c_rise: cover property (@(posedge clock) disable iff (!rstn) rise_evt ##1 rise_q);
   c_fall: cover property (@(posedge clock) disable iff (!rstn) fall_evt ##1 fall_q);
   c_clear: cover property (@(posedge clock) disable iff (!rstn) rise_q ##1 !rise_q);
   c_irq: cover property (@(posedge clock) disable iff (!rstn) rise_irq && fall_irq);
endmodule

// ===== sim/cmp_one_analog_model.sv
// Purpose: behavioural analog core of comparator one
// Assumes: diff_mv is noninverting minus inverting input, in millivolts
// Notes: input select codes are not modelled; only the voltage difference matters
`timescale 1ns/1ns
module cmp_one_analog_model (
   input wire cmp_one_pkg::analog_ctrl_s analog_ctrl,
   input wire logic signed [15:0] diff_mv,
   output logic cmp_raw
);
   logic state;
   function automatic int hyst_mv(input logic [1:0] c);
      return (c == 2'h3) ? 20 : 5 * c;
   endfunction
   function automatic int resp_ns(input logic [1:0] c);
      case (c)
         2'h0: return 100;
         2'h1: return 175;
         2'h2: return 320;
         default: return 1050;
      endcase
   endfunction
   initial begin
      state = 1'b0;
      cmp_raw = 1'b0;
   end
   // powered-down core sits low, so re-enabling starts from a known level
   always @(analog_ctrl or diff_mv) begin
      if (!analog_ctrl.enable) state = 1'b0;
      else if (!state && diff_mv > hyst_mv(analog_ctrl.pos_hyst)) state = 1'b1;
      else if (state && diff_mv < -hyst_mv(analog_ctrl.neg_hyst)) state = 1'b0;
      cmp_raw <= #(resp_ns(analog_ctrl.resp_mode)) state;
   end
endmodule

// ===== sim/comparator_one_control_regs_test.sv
// Purpose: self-checking bench for the comparator one register bank
// Assumes: analog core model on cmp_raw, one byte access at a time
// Notes: rows cover readback masks; edge flags are exercised by hand
`timescale 1ns/1ns
module comparator_one_control_regs_test;
   logic clock, rstn, wr_en, rd_en, rd_hit, cmp_raw, cmp_pin_out, rise_irq, fall_irq;
   logic [7:0] addr, wr_data, rd_data, v;
   logic signed [15:0] diff_mv;
   cmp_one_pkg::analog_ctrl_s analog_ctrl;
   int err_total = 0;
   int samples_checked = 0;
   // address, write data, expected readback
   localparam logic [23:0] rows [12] = '{24'h9a0f0f, 24'h9a0505, 24'h9a0a0a, 24'h9a0000, 24'h9cff33,
      24'h9cc202, 24'h9c0101, 24'h9e00cc, 24'h9e21ed, 24'h9e12de, 24'h9effff, 24'h9c3030};
   cmp_one_regs dut (.clock(clock), .rstn(rstn), .addr(addr), .wr_en(wr_en), .wr_data(wr_data),
      .rd_en(rd_en), .rd_data(rd_data), .rd_hit(rd_hit), .cmp_raw(cmp_raw), .analog_ctrl(analog_ctrl),
      .cmp_pin_out(cmp_pin_out), .rise_irq(rise_irq), .fall_irq(fall_irq));
   cmp_one_analog_model partner (.analog_ctrl(analog_ctrl), .diff_mv(diff_mv), .cmp_raw(cmp_raw));
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      samples_checked++;
      if (got !== exp) begin
         $display("mismatch %s expected %h seen %h", name, exp, got);
         err_total++;
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      addr <= a;
      wr_data <= d;
      wr_en <= 1'b1;
      @(posedge clock);
      wr_en <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge clock);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge clock);
      rd_en <= 1'b0;
      #1 v = rd_data;
   endtask
   // slowest response mode is about 105 cycles, so 200 is a safe bound
   task automatic settle(input logic lvl);
      for (int i = 0; i < 200 && cmp_pin_out !== lvl; i++) begin
         @(posedge clock);
         #1;
      end
      chk("cmp_pin_out", {15'h0, lvl}, {15'h0, cmp_pin_out});
   endtask
   task automatic final_report;
      if (err_total == 0 && samples_checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   initial begin
      #100000;
      err_total++;
      final_report;
   end
   initial begin
      rstn = 1'b0;
      wr_en = 1'b0;
      rd_en = 1'b0;
      addr = 8'h00;
      wr_data = 8'h00;
      diff_mv = -16'sd50;
      repeat (20) @(posedge clock);
      rstn <= 1'b1;
      rd(8'h9a);
      chk("control reset", 16'h0000, {8'h0, v});
      rd(8'h9c);
      chk("mode reset", 16'h0002, {8'h0, v});
      rd(8'h9e);
      chk("input select reset", 16'h00ff, {8'h0, v});
      chk("analog_ctrl reset", 16'h003e, {5'h0, analog_ctrl});
      foreach (rows[i]) begin
         wr(rows[i][23:16], rows[i][15:8]);
         rd(rows[i][23:16]);
         chk("row readback", {8'h0, rows[i][7:0]}, {8'h0, v});
      end
      rd(8'h9b);
      chk("unmapped data", 16'h0000, {8'h0, v});
      chk("unmapped hit", 16'h0000, {15'h0, rd_hit});
      wr(8'h9e, 8'h12);
      wr(8'h9a, 8'h8e);
      chk("analog_ctrl", 16'h0798, {5'h0, analog_ctrl});
      @(posedge clock) diff_mv <= 16'sd50;
      settle(1'b1);
      rd(8'h9a);
      chk("rise flagged", 16'h00ee, {8'h0, v});
      chk("rise_irq", 16'h0001, {15'h0, rise_irq});
      chk("fall_irq", 16'h0000, {15'h0, fall_irq});
      wr(8'h9a, 8'h8e);
      rd(8'h9a);
      chk("rise cleared", 16'h00ce, {8'h0, v});
      chk("rise_irq clear", 16'h0000, {15'h0, rise_irq});
      @(posedge clock) diff_mv <= -16'sd50;
      settle(1'b0);
      rd(8'h9a);
      chk("fall flagged", 16'h009e, {8'h0, v});
      chk("fall_irq", 16'h0001, {15'h0, fall_irq});
      wr(8'h9c, 8'h00);
      chk("fall_irq masked", 16'h0000, {15'h0, fall_irq});
      wr(8'h9a, 8'h00);
      @(posedge clock) diff_mv <= 16'sd50;
      repeat (150) @(posedge clock);
      rd(8'h9a);
      chk("disabled control", 16'h0000, {8'h0, v});
      chk("disabled pin", 16'h0000, {15'h0, cmp_pin_out});
      // core output still high for ~10 cycles after disabling, so the gate is what holds the pin low
      wr(8'h9a, 8'h80);
      settle(1'b1);
      wr(8'h9a, 8'h00);
      repeat (2) @(posedge clock);
      #1 chk("gated pin", 16'h0000, {15'h0, cmp_pin_out});
      rd(8'h9a);
      chk("disable fall", 16'h0010, {8'h0, v});
      @(posedge clock) rstn <= 1'b0;
      repeat (3) @(posedge clock);
      rstn <= 1'b1;
      rd(8'h9c);
      chk("mode rereset", 16'h0002, {8'h0, v});
      rd(8'h9a);
      chk("control rereset", 16'h0000, {8'h0, v});
      final_report;
   end
endmodule
